// ==== sstop_map.svh ====
// Constants for the dual-channel safety stop monitor
`ifndef SSTOP_MAP_SVH
`define SSTOP_MAP_SVH
`define SSTOP_SEL_W 8
`define SSTOP_CODE_W 9
`define SSTOP_FN_SAFE_POS 9'h050
`define SSTOP_FN_SAFE_NEG 9'h0b4
`define SSTOP_FN_FAULT_FREE_SIGNAL_POS 9'h051
`define SSTOP_FN_FAULT_FREE_SIGNAL_NEG 9'h0b5
`define SSTOP_SYNC_W 3
`endif

// ==== sstop_pkg.sv ====
// Types for the dual-channel safety stop monitor
package sstop_pkg;
	typedef enum logic [2:0] {
		SSTOP_PNL_NONE = 3'h0,
		SSTOP_PNL_SAFE_FAULT = 3'h1,
		SSTOP_PNL_CPU_FAULT = 3'h2,
		SSTOP_PNL_STOP_IND = 3'h3
	} sstop_panel_e;
	typedef struct packed {
		logic stop_channel_a;
		logic stop_channel_b;
	} sstop_chan_s;
	typedef struct packed {
		logic power_on;
		logic safety_fault;
		logic cpu_fault;
	} sstop_cond_s;
	typedef struct packed {
		logic [8:0] output_select_first;
		logic [8:0] output_select_second;
		logic [8:0] output_select_third;
	} sstop_sel_s;
endpackage

// ==== sstop_sync.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sstop_sync (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Pin in, filtered level out
	input wire logic pin_i,
	output logic level_o
);
	logic [2:0] stg_r;
	logic [2:0] stg_nxt;
	logic level_r;
	logic level_nxt;

	always_comb begin
		stg_nxt = {stg_r[1:0], pin_i};
		level_nxt = level_r;
		// Stage 0 feeds only stage 1; compare later stages
		if (stg_r[1] == stg_r[2]) begin
			level_nxt = stg_r[2];
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			stg_r <= 3'h0;
			level_r <= 1'h0;
		end else begin
			stg_r <= stg_nxt;
			level_r <= level_nxt;
		end
	end

	assign level_o = level_r;
endmodule // sstop_sync

// ==== sstop_monitor.sv ====
// Safety stop supervisor: channel evaluation, status outputs, routing
`timescale 1ns/1ps
module sstop_monitor
	import sstop_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Stop channels from relay module, high = shorted
	input wire sstop_chan_s chan_i,
	// Internal condition, same clock
	input wire sstop_cond_s cond_i,
	input wire logic running_i,
	// Output terminal selectors
	input wire sstop_sel_s sel_i,
	// Power stage and panel
	output logic power_enable_o,
	output sstop_panel_e panel_o,
	// Open-collector pins, low = transistor conducts
	output logic monitor_pin_oc_o,
	output logic running_pin_oc_o,
	output logic [2:0] term_oc_o,
	// Raw status levels
	output logic safe_stop_o,
	output logic fault_free_o
);
	`include "sstop_map.svh"

	logic ch_a;
	logic ch_b;
	logic pwr_en_r, pwr_en_nxt;
	logic safe_r, safe_nxt;
	logic free_r, free_nxt;
	logic mon_oc_r, mon_oc_nxt;
	logic run_oc_r, run_oc_nxt;
	logic [2:0] term_oc_r, term_oc_nxt;
	sstop_panel_e panel_r, panel_nxt;
	logic [8:0] sel_arr [3];
	logic [1:0] sel_dec [3];
	logic any_safe_sel;
	logic any_fault_free_signal_sel;
	logic fault;

	// ----------------------------------------
	// Channel synchronisers
	// ----------------------------------------
	sstop_sync u_sync_a (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.pin_i(chan_i.stop_channel_a),
		.level_o(ch_a)
	);
	sstop_sync u_sync_b (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.pin_i(chan_i.stop_channel_b),
		.level_o(ch_b)
	);

	// ----------------------------------------
	// Terminal selection decode
	// ----------------------------------------
	function automatic logic [1:0] sel_decode(input logic [8:0] code);
		// Returns {fault_free select, monitor select}
		sel_decode = {(code == `SSTOP_FN_FAULT_FREE_SIGNAL_POS) || (code == `SSTOP_FN_FAULT_FREE_SIGNAL_NEG),
			(code == `SSTOP_FN_SAFE_POS) || (code == `SSTOP_FN_SAFE_NEG)};
	endfunction

	function automatic logic route_level(input logic [8:0] code, input logic safe, input logic free,
		input logic dflt);
		// Positive codes conduct when asserted; negative codes invert
		unique case (code)
			`SSTOP_FN_SAFE_POS: route_level = safe;
			`SSTOP_FN_SAFE_NEG: route_level = !safe;
			`SSTOP_FN_FAULT_FREE_SIGNAL_POS: route_level = free;
			`SSTOP_FN_FAULT_FREE_SIGNAL_NEG: route_level = !free;
			default: route_level = dflt;
		endcase
	endfunction

	always_comb begin
		sel_arr[0] = sel_i.output_select_first;
		sel_arr[1] = sel_i.output_select_second;
		sel_arr[2] = sel_i.output_select_third;
		any_safe_sel = 1'b0;
		any_fault_free_signal_sel = 1'b0;
		// A function result cannot be bit-selected directly, so keep it per selector
		for (int i = 0; i < 3; i++) begin
			sel_dec[i] = sel_decode(sel_arr[i]);
			any_safe_sel = any_safe_sel | sel_dec[i][0];
			any_fault_free_signal_sel = any_fault_free_signal_sel | sel_dec[i][1];
		end
	end

	// ----------------------------------------
	// Safety decision
	// ----------------------------------------
	assign fault = cond_i.safety_fault | cond_i.cpu_fault;

	always_comb begin
		pwr_en_nxt = 1'b0;
		safe_nxt = 1'b0;
		free_nxt = 1'b0;
		panel_nxt = SSTOP_PNL_NONE;
		if (cond_i.power_on) begin
			if (ch_a && ch_b) begin
				pwr_en_nxt = !fault;
				free_nxt = !fault;
			end else if (!ch_a && !ch_b) begin
				safe_nxt = !fault;
				free_nxt = !fault;
				if (!fault) begin
					panel_nxt = SSTOP_PNL_STOP_IND;
				end
			end
			// Single open channel leaves power and status off; a fault still sets the panel code
			if (cond_i.safety_fault) begin
				panel_nxt = SSTOP_PNL_SAFE_FAULT;
			end else if (cond_i.cpu_fault) begin
				panel_nxt = SSTOP_PNL_CPU_FAULT;
			end
		end
	end

	// ----------------------------------------
	// Open-collector pin drive
	// ----------------------------------------
	always_comb begin
		// Dedicated pin keeps the monitor unless moved elsewhere
		mon_oc_nxt = any_safe_sel ? 1'b1 : !safe_nxt;
		// Selector first applies to the running pin; 81 blocks restart
		run_oc_nxt = !route_level(sel_arr[0], safe_nxt, free_nxt,
			running_i && pwr_en_nxt);
		term_oc_nxt = 3'h7;
		for (int i = 0; i < 3; i++) begin
			term_oc_nxt[i] = !route_level(sel_arr[i], safe_nxt, free_nxt, 1'b0);
		end
		if (!cond_i.power_on) begin
			mon_oc_nxt = 1'b1;
			run_oc_nxt = 1'b1;
			term_oc_nxt = 3'h7;
		end
	end

	// ----------------------------------------
	// Status registers
	// ----------------------------------------
	// Reset leaves the drive in its safe state: power off, nothing indicated
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pwr_en_r <= 1'b0;
			safe_r <= 1'b0;
			free_r <= 1'b0;
			panel_r <= SSTOP_PNL_NONE;
		end else begin
			pwr_en_r <= pwr_en_nxt;
			safe_r <= safe_nxt;
			free_r <= free_nxt;
			panel_r <= panel_nxt;
		end
	end

	// ----------------------------------------
	// Pin registers
	// ----------------------------------------
	// All transistors off in reset so the relay sees no false feedback
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mon_oc_r <= 1'b1;
			run_oc_r <= 1'b1;
			term_oc_r <= 3'h7;
		end else begin
			mon_oc_r <= mon_oc_nxt;
			run_oc_r <= run_oc_nxt;
			term_oc_r <= term_oc_nxt;
		end
	end

	assign power_enable_o = pwr_en_r;
	assign safe_stop_o = safe_r;
	assign fault_free_o = free_r;
	assign panel_o = panel_r;
	assign monitor_pin_oc_o = mon_oc_r;
	assign running_pin_oc_o = run_oc_r;
	assign term_oc_o = term_oc_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	sequence both_short_ok;
		cond_i.power_on && ch_a && ch_b && !fault;
	endsequence

	sequence both_open_ok;
		cond_i.power_on && !ch_a && !ch_b && !fault;
	endsequence

	sequence powered_fault;
		cond_i.power_on && fault;
	endsequence

	sequence power_dropped;
		!cond_i.power_on;
	endsequence

	// Pin goes high and holds for three samples
	sequence chan_a_rise_held;
		$rose(chan_i.stop_channel_a) ##1 chan_i.stop_channel_a [*3];
	endsequence

	// Pin goes low and holds for three samples
	sequence chan_a_fall_held;
		$fell(chan_i.stop_channel_a) ##1 !chan_i.stop_channel_a [*3];
	endsequence

	enable_when_ok_a: assert property (both_short_ok |=> power_enable_o)
		else $error("power output not enabled when safe to run");
	enable_only_ok_a: assert property (!(ch_a && ch_b) |=> !power_enable_o)
		else $error("power output enabled with a channel open");
	monitor_cause_a: assert property (safe_stop_o |-> $past(!ch_a && !ch_b && !fault))
		else $error("monitor asserted without both channels open");
	free_on_fault_a: assert property (fault |=> !fault_free_o)
		else $error("fault-free output stayed on during fault");
	single_open_a: assert property ((ch_a != ch_b) |=> !safe_stop_o && !fault_free_o && !power_enable_o)
		else $error("single open channel not shut off");
	panel_fault_a: assert property (cond_i.power_on && cond_i.safety_fault |=> panel_o == SSTOP_PNL_SAFE_FAULT)
		else $error("safety fault code not shown");
	panel_stop_a: assert property (cond_i.power_on && !ch_a && !ch_b && !fault |=> panel_o == SSTOP_PNL_STOP_IND)
		else $error("stop indication not shown");
	oc_polarity_a: assert property (sel_i.output_select_first == `SSTOP_FN_FAULT_FREE_SIGNAL_POS && cond_i.power_on
		|=> running_pin_oc_o == !fault_free_o)
		else $error("running pin does not follow fault-free");
	power_off_a: assert property (!cond_i.power_on |=> monitor_pin_oc_o && running_pin_oc_o && !power_enable_o)
		else $error("outputs active while power off");
	sync_delay_a: assert property (chan_a_rise_held |=> ch_a)
		else $error("channel synchroniser did not settle");
	sync_release_a: assert property (chan_a_fall_held |=> !ch_a)
		else $error("channel synchroniser did not release");
	monitor_when_open_a: assert property (both_open_ok |=> safe_stop_o)
		else $error("monitor not asserted with both channels open");
	monitor_off_fault_a: assert property (powered_fault |=> !safe_stop_o)
		else $error("monitor asserted during fault");
	free_when_ok_a: assert property (cond_i.power_on && !fault && (ch_a == ch_b) |=> fault_free_o)
		else $error("fault-free output missing without fault");
	panel_cpu_a: assert property (powered_fault and (!cond_i.safety_fault) |=> panel_o == SSTOP_PNL_CPU_FAULT)
		else $error("processor fault code not shown");
	monitor_pin_a: assert property (cond_i.power_on && !any_safe_sel |=> monitor_pin_oc_o == !safe_stop_o)
		else $error("monitor pin does not follow monitor level");
	monitor_moved_a: assert property (any_safe_sel |=> monitor_pin_oc_o)
		else $error("monitor pin still driven after rerouting");
	run_negative_a: assert property (sel_i.output_select_first == `SSTOP_FN_FAULT_FREE_SIGNAL_NEG && cond_i.power_on
		|=> running_pin_oc_o == fault_free_o)
		else $error("running pin negative logic wrong");
	run_default_a: assert property (sel_dec[0] == 2'h0 && sel_i.output_select_first != `SSTOP_FN_SAFE_POS
		&& sel_i.output_select_first != `SSTOP_FN_SAFE_NEG && cond_i.power_on
		|=> running_pin_oc_o == !($past(running_i) && power_enable_o))
		else $error("running pin lost running indication");
	run_blocks_a: assert property (sel_i.output_select_first == `SSTOP_FN_FAULT_FREE_SIGNAL_POS && powered_fault
		|=> running_pin_oc_o)
		else $error("running pin conducts during fault");
	status_off_a: assert property (power_dropped |=> !safe_stop_o && !fault_free_o)
		else $error("status levels active while power off");
	term_off_a: assert property (power_dropped and any_fault_free_signal_sel |=> term_oc_o == 3'h7)
		else $error("terminal conducts while power off");
endmodule // sstop_monitor

// ==== sstop_relay.sv ====
// Model of the external two-channel safety relay module
`timescale 1ns/1ps
module sstop_relay
	import sstop_pkg::*;
(
	// Clock
	input wire logic core_clk_i,
	// Commands: bit 1 opens channel a, bit 0 channel b
	input wire logic [1:0] open_i,
	input wire logic interlock_i,
	// Running pin feedback, low = conducting
	input wire logic relay_feedback_a_i,
	input wire logic relay_feedback_b_i,
	// Stop channels, high = shorted
	output sstop_chan_s chan_o
);
	logic restart_ok;
	// With interlock_i high, only a conducting feedback pair lets a channel close again
	assign restart_ok = !interlock_i || (!relay_feedback_a_i && !relay_feedback_b_i);
	initial chan_o = '0;
	always @(posedge core_clk_i) begin
		if (open_i[1])
			chan_o.stop_channel_a <= 1'b0;
		else if (restart_ok)
			chan_o.stop_channel_a <= 1'b1;
		if (open_i[0])
			chan_o.stop_channel_b <= 1'b0;
		else if (restart_ok)
			chan_o.stop_channel_b <= 1'b1;
	end
endmodule // sstop_relay

// ==== tb_top.sv ====
// Testbench for the safety stop monitor
`timescale 1ns/1ps
`include "sstop_map.svh"
module tb_top;
	import sstop_pkg::*;
	logic core_clk_i = 0;
	logic rst_i = 1;
	sstop_cond_s cond_i = '0;
	logic running_i = 0;
	sstop_sel_s sel_i = '0;
	logic [1:0] open_req = 2'h3;
	logic fb_en = 0;
	sstop_chan_s chan_i;
	logic power_enable_o, monitor_pin_oc_o, running_pin_oc_o, safe_stop_o, fault_free_o;
	sstop_panel_e panel_o;
	logic [2:0] term_oc_o;
	int errors = 0;
	int compares = 0;
	localparam logic [8:0] CODES [5] = '{`SSTOP_FN_SAFE_POS, `SSTOP_FN_SAFE_NEG, `SSTOP_FN_FAULT_FREE_SIGNAL_POS,
		`SSTOP_FN_FAULT_FREE_SIGNAL_NEG, 9'h0ff};
	always #25 core_clk_i = ~core_clk_i;
	sstop_monitor dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .chan_i(chan_i), .cond_i(cond_i),
		.running_i(running_i), .sel_i(sel_i), .power_enable_o(power_enable_o), .panel_o(panel_o),
		.monitor_pin_oc_o(monitor_pin_oc_o), .running_pin_oc_o(running_pin_oc_o), .term_oc_o(term_oc_o),
		.safe_stop_o(safe_stop_o), .fault_free_o(fault_free_o));
	sstop_relay relay (.core_clk_i(core_clk_i), .open_i(open_req), .interlock_i(fb_en),
		.relay_feedback_a_i(running_pin_oc_o), .relay_feedback_b_i(running_pin_oc_o), .chan_o(chan_i));
	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	task automatic chk_bit(input string n, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic chk_pnl(input sstop_panel_e e);
		compares++;
		if (panel_o !== e) begin
			errors++;
			$display("wrong value panel_o expected %0d seen %0d", e, panel_o);
		end
	endtask
	// Inputs move 5 ns after the edge, outputs read there too
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk_i);
		#5;
	endtask
	task automatic st(input logic pe, input logic sf, input logic ff);
		chk_bit("power_enable_o", pe, power_enable_o);
		chk_bit("safe_stop_o", sf, safe_stop_o);
		chk_bit("fault_free_o", ff, fault_free_o);
		chk_bit("monitor_pin_oc_o", ~sf, monitor_pin_oc_o);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_power_off;
		open_req = 2'h0;
		settle(8);
		st(1'b0, 1'b0, 1'b0);
		$display("power off test done");
	endtask
	task automatic t_table;
		logic sf;
		sstop_panel_e pn;
		for (int c = 0; c < 4; c++) begin
			for (int f = 0; f < 3; f++) begin
				cond_i = '{1'b1, f == 1, f == 2};
				open_req = 2'(c);
				settle(8);
				sf = c == 3 && f == 0;
				pn = f == 1 ? SSTOP_PNL_SAFE_FAULT : f == 2 ? SSTOP_PNL_CPU_FAULT : sf ? SSTOP_PNL_STOP_IND : SSTOP_PNL_NONE;
				st(c == 0 && f == 0, sf, (c == 0 || c == 3) && f == 0);
				chk_pnl(pn);
			end
		end
		$display("truth table test done");
	endtask
	task automatic t_route;
		logic sf, ff, pe, e;
		logic [1:0] chs [3] = '{2'h3, 2'h0, 2'h1};
		cond_i = '{1'b1, 1'b0, 1'b0};
		running_i = 1'b1;
		foreach (chs[s]) begin
			open_req = chs[s];
			sel_i = '0;
			settle(8);
			sf = chs[s] == 2'h3;
			pe = chs[s] == 2'h0;
			ff = sf || pe;
			for (int k = 0; k < 3; k++) begin
				for (int c = 0; c < 5; c++) begin
					sel_i = sstop_sel_s'(27'(CODES[c]) << (9 * (2 - k)));
					settle(2);
					case (c)
						0: e = ~sf;
						1: e = sf;
						2: e = ~ff;
						3: e = ff;
						default: e = 1'b1;
					endcase
					chk_bit("term_oc_o", e, term_oc_o[k]);
					chk_bit("monitor_pin_oc_o", c < 2 ? 1'b1 : ~sf, monitor_pin_oc_o);
					chk_bit("running_pin_oc_o", (k == 0 && c < 4) ? e : ~pe, running_pin_oc_o);
				end
			end
		end
		sel_i = '0;
		$display("routing test done");
	endtask
	task automatic t_sync;
		open_req = 2'h3;
		settle(8);
		open_req = 2'h0;
		settle(2);
		chk_bit("power_enable_o", 1'b0, power_enable_o);
		settle(6);
		chk_bit("power_enable_o", 1'b1, power_enable_o);
		$display("sync test done");
	endtask
	task automatic t_restart;
		sel_i.output_select_first = `SSTOP_FN_FAULT_FREE_SIGNAL_POS;
		fb_en = 1'b1;
		open_req = 2'h3;
		settle(8);
		open_req = 2'h0;
		settle(10);
		chk_bit("power_enable_o", 1'b1, power_enable_o);
		cond_i.safety_fault = 1'b1;
		settle(2);
		chk_bit("running_pin_oc_o", 1'b1, running_pin_oc_o);
		open_req = 2'h3;
		settle(8);
		open_req = 2'h0;
		settle(10);
		chk_bit("power_enable_o", 1'b0, power_enable_o);
		cond_i.safety_fault = 1'b0;
		settle(12);
		chk_bit("power_enable_o", 1'b1, power_enable_o);
		$display("restart block test done");
	endtask
	task automatic stop_test;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		settle(5);
		rst_i = 1'b0;
		t_power_off();
		t_table();
		t_route();
		t_sync();
		t_restart();
		stop_test();
	end
endmodule // tb_top
